// [include/fpseu_pkg.sv]
// Constants, state type and field layout of the floating status and exception unit.
// Assumes one clock; the CPU sequencer pulses one completed operation per cycle at most.
//
// Function
// - Global interrupt disable set suppresses every floating trap.
// - Trap on memory operand with sign one and exponent zero when enabled.
// - Accumulator operands (mode zero) never raise the undefined operand trap.
// - A negative-zero-exponent result is stored only together with a recorded exception.
// - Enabled underflow traps; fraction kept, exponent keeps its low eight bits.
// - Enabled overflow traps; fraction kept, exponent keeps its low eight bits.
// - Disabled overflow raises no trap and stores exact zero.
// - Disabled underflow raises no trap and stores exact zero.
// - Failed integer conversion clears destination; traps only when its enable is set.
// - Conversion fails when the integer exceeds the selected short or long width.
// - Precision mode bit set selects double, clear selects single.
// - Long integer mode selects 32-bit integers, else 16-bit.
// - Truncate mode chops; otherwise round up when the first dropped bit is one.
// - Each stored operation updates negative, zero, overflow and carry condition bits.
// - Every floating exception uses the one vector at octal 244.
// - Cause codes: 2 opcode, 4 divide, 6 conversion, 8 over, 10 under, 12 undefined.
// - Recording an exception captures the faulting instruction address.
// - Cause and address update only on divide, opcode, or enabled exceptions.
// - Global disable does not stop cause and address from updating.
// - Cause and address registers are read only.
// - Mode zero selects accumulator; auto steps are 4 single, 8 double.
// - Mode zero allows accumulators 0 to 5; memory modes allow 0 to 3.
// - Most significant word sits at the lowest memory address.
// - Arithmetic error bit set on recorded exceptions; only status load clears it.
// - Sign one with exponent zero is the undefined operand; all zero is exact zero.
package fpseu_pkg;

  localparam int BIT_ERR = 15;
  localparam int BIT_GID = 14;
  localparam int BIT_UNDEF_EN = 11;
  localparam int BIT_UNF_EN = 10;
  localparam int BIT_OVF_EN = 9;
  localparam int BIT_CVT_EN = 8;
  localparam int BIT_DBL = 7;
  localparam int BIT_LONG = 6;
  localparam int BIT_CHOP = 5;
  localparam int BIT_NEG = 3;
  localparam int BIT_ZERO = 2;
  localparam int BIT_OVF = 1;
  localparam int BIT_CARRY = 0;

  // Bits 13, 12 and 4 are reserved and always read zero
  localparam logic [15:0] STS_WMASK = 16'hCFEF;
  localparam logic [15:0] STS_RESET = 16'h0000;
  localparam logic [3:0] CAUSE_RESET = 4'h0;
  localparam logic [15:0] ADDR_RESET = 16'h0000;

  localparam logic [3:0] CAUSE_OPCODE = 4'h2;
  localparam logic [3:0] CAUSE_DIVZ = 4'h4;
  localparam logic [3:0] CAUSE_CVT = 4'h6;
  localparam logic [3:0] CAUSE_OVF = 4'h8;
  localparam logic [3:0] CAUSE_UNF = 4'hA;
  localparam logic [3:0] CAUSE_UNDEF = 4'hC;

  // Octal 244
  localparam logic [8:0] TRAP_VECTOR = 9'h0A4;

  localparam logic [3:0] STEP_SINGLE = 4'h4;
  localparam logic [3:0] STEP_DOUBLE = 4'h8;

  localparam int FRAC_W = 56;
  localparam int SGL_W = 24;
  localparam logic signed [9:0] EXP_MAX = 10'sd255;
  localparam logic signed [9:0] EXP_MIN = 10'sd1;
  localparam int CVT_W = 48;

  typedef struct packed {
    logic [15:0] sts;
    logic [3:0] cause;
    logic [15:0] addr;
    logic trap;
    logic [8:0] vec;
    logic rvalid;
    logic [63:0] res;
    logic [31:0] ires;
    logic [3:0] step;
  } fpseu_state_t;

endpackage

// [rtl/fpseu_round.sv]
// Chop or round of a normalised fraction with renormalisation on carry.
// Assumes the hidden bit sits at the top of the raw fraction.
`timescale 1ns/10ps
module fpseu_round
  import fpseu_pkg::*;
#(
  parameter int FW = FRAC_W
)
(
  input wire logic [FW:0] frac_raw,
  input wire logic signed [9:0] exp_in,
  input wire logic dbl,
  input wire logic chop,
  output logic [FW-1:0] frac_out,
  output logic signed [9:0] exp_out
);

  logic [FW-1:0] mask;
  logic [FW-1:0] lsb;
  logic rbit;
  logic [FW:0] sum;

  always_comb
  begin
    mask = dbl ? {FW{1'b1}} : {{SGL_W{1'b1}}, {(FW-SGL_W){1'b0}}};
    lsb = dbl ? {{(FW-1){1'b0}}, 1'b1} : {{(SGL_W-1){1'b0}}, 1'b1, {(FW-SGL_W){1'b0}}};
    rbit = dbl ? frac_raw[0] : frac_raw[FW-SGL_W];
    sum = {1'b0, frac_raw[FW:1] & mask} + ((!chop && rbit) ? {1'b0, lsb} : {(FW+1){1'b0}});
    if (sum[FW])
    begin
      frac_out = sum[FW:1] & mask;
      exp_out = exp_in + 10'sd1;
    end
    else
    begin
      frac_out = sum[FW-1:0];
      exp_out = exp_in;
    end
  end

endmodule

// [rtl/fpseu_opchk.sv]
// Operand addressing checks: accumulator range, undefined operand, autostep size.
// Assumes msw is the word fetched from the lowest operand address.
`timescale 1ns/10ps
module fpseu_opchk
  import fpseu_pkg::*;
(
  input wire logic [2:0] mode,
  input wire logic [2:0] ac,
  input wire logic [15:0] msw,
  input wire logic uses_src,
  input wire logic dbl,
  output logic illegal_ac,
  output logic undef_src,
  output logic [3:0] step
);

  always_comb
  begin
    illegal_ac = (mode == 3'h0) ? (ac > 3'h5) : (ac > 3'h3);
    undef_src = uses_src && (mode != 3'h0) && msw[15] && (msw[14:7] == 8'h00);
    step = dbl ? STEP_DOUBLE : STEP_SINGLE;
  end

endmodule

// [rtl/fpseu_unit.sv]
// Floating status word, exception cause and address capture, result fix-up and trap request.
// Assumes the CPU sequencer presents one finished operation per op_valid pulse and
// takes trap_req with trap_vector on the following cycle.
`timescale 1ns/10ps
module fpseu_unit
  import fpseu_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic stat_load,
  input wire logic [15:0] stat_load_data,
  input wire logic op_valid,
  input wire logic [15:0] instr_addr,
  input wire logic op_illegal,
  input wire logic op_div_zero,
  input wire logic [2:0] op_mode,
  input wire logic [2:0] op_ac,
  input wire logic op_uses_src,
  input wire logic [15:0] src_msw,
  input wire logic op_to_int,
  input wire logic signed [CVT_W-1:0] cvt_value,
  input wire logic op_zero,
  input wire logic res_sign,
  input wire logic signed [9:0] res_exp,
  input wire logic [FRAC_W:0] res_frac_raw,
  input wire logic op_carry,
  output logic [15:0] status_word,
  output logic [3:0] cause_code,
  output logic [15:0] fault_addr,
  output logic trap_req,
  output logic [8:0] trap_vector,
  output logic res_valid,
  output logic [63:0] res_data,
  output logic [31:0] int_result,
  output logic [3:0] addr_step
);

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // integer width check
  function automatic logic int_fits(input logic signed [CVT_W-1:0] v, input logic long_mode);
    logic [CVT_W-1:0] u;
    u = v;
    if (long_mode)
      int_fits = (u[CVT_W-1:31] == {(CVT_W-31){1'b0}}) || (u[CVT_W-1:31] == {(CVT_W-31){1'b1}});
    else
      int_fits = (u[CVT_W-1:15] == {(CVT_W-15){1'b0}}) || (u[CVT_W-1:15] == {(CVT_W-15){1'b1}});
  endfunction

  function automatic logic is_neg_zero_exp(input logic [15:0] w);
    is_neg_zero_exp = w[15] && (w[14:7] == 8'h00);
  endfunction

  fpseu_state_t s_q;
  fpseu_state_t s_d;

  logic illegal_ac;
  logic undef_src;
  logic [3:0] step;
  logic [FRAC_W-1:0] frac_r;
  logic signed [9:0] exp_r;

  logic ev_illegal;
  logic ev_undef;
  logic ev_divz;
  logic ev_cvt;
  logic ev_ovf;
  logic ev_unf;
  logic record;
  logic store;
  logic cvt_ok;
  logic [63:0] fres;
  logic [31:0] ires;
  logic [15:0] sts_base;

  // ----------------------------------------
  // Operand checks and rounding
  // ----------------------------------------
  fpseu_opchk u_opchk (
    .mode(op_mode),
    .ac(op_ac),
    .msw(src_msw),
    .uses_src(op_uses_src),
    .dbl(s_q.sts[BIT_DBL]),
    .illegal_ac(illegal_ac),
    .undef_src(undef_src),
    .step(step)
  );

  fpseu_round #(.FW(FRAC_W)) u_round (
    .frac_raw(res_frac_raw),
    .exp_in(res_exp),
    .dbl(s_q.sts[BIT_DBL]),
    .chop(s_q.sts[BIT_CHOP]),
    .frac_out(frac_r),
    .exp_out(exp_r)
  );

  // ----------------------------------------
  // Exception detection
  // ----------------------------------------
  always_comb
  begin
    ev_illegal = op_valid && (op_illegal || illegal_ac);
    ev_undef = op_valid && !ev_illegal && undef_src && s_q.sts[BIT_UNDEF_EN];
    ev_divz = op_valid && !ev_illegal && !ev_undef && op_div_zero;
    cvt_ok = int_fits(cvt_value, s_q.sts[BIT_LONG]);
    ev_cvt = op_valid && op_to_int && !cvt_ok;
    // Range is judged on the rounded exponent, as a rounding carry can overflow
    ev_ovf = op_valid && !op_to_int && !op_zero && (exp_r > EXP_MAX);
    ev_unf = op_valid && !op_to_int && !op_zero && (exp_r < EXP_MIN);
    record = ev_illegal || ev_undef || ev_divz
      || (ev_cvt && s_q.sts[BIT_CVT_EN])
      || (ev_ovf && s_q.sts[BIT_OVF_EN])
      || (ev_unf && s_q.sts[BIT_UNF_EN]);
    // Trapped operand or opcode faults happen before execution, so nothing is stored
    store = op_valid && !ev_illegal && !ev_undef && !ev_divz;
  end

  // ----------------------------------------
  // Result fix-up
  // ----------------------------------------
  always_comb
  begin
    // most significant word at bits 63:48, lowest address
    fres = {res_sign, exp_r[7:0], frac_r[FRAC_W-2:0]};
    if (op_zero)
      fres = 64'h0000_0000_0000_0000;
    else if (ev_ovf && !s_q.sts[BIT_OVF_EN])
      fres = 64'h0000_0000_0000_0000;
    else if (ev_unf && !s_q.sts[BIT_UNF_EN])
      fres = 64'h0000_0000_0000_0000;
    if (!cvt_ok)
      ires = 32'h0000_0000;
    else if (s_q.sts[BIT_LONG])
      ires = cvt_value[31:0];
    else
      ires = {{16{cvt_value[15]}}, cvt_value[15:0]};
  end

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb
  begin
    s_d = s_q;
    s_d.vec = TRAP_VECTOR;
    s_d.step = step;
    s_d.rvalid = 1'b0;
    s_d.trap = 1'b0;
    // Status load writes mode, enable, error and condition bits
    sts_base = stat_load ? (stat_load_data & STS_WMASK) : s_q.sts;
    s_d.sts = sts_base;
    // A stored operation's condition bits override loaded bits 3:0
    if (store)
    begin
      s_d.rvalid = 1'b1;
      if (op_to_int)
      begin
        s_d.ires = ires;
        s_d.sts[BIT_NEG] = ires[31];
        s_d.sts[BIT_ZERO] = (ires == 32'h0000_0000);
        s_d.sts[BIT_OVF] = 1'b0;
      end
      else
      begin
        s_d.res = s_q.sts[BIT_DBL] ? fres : {fres[63:32], 32'h0000_0000};
        s_d.sts[BIT_NEG] = fres[63];
        s_d.sts[BIT_ZERO] = (fres[62:55] == 8'h00);
        s_d.sts[BIT_OVF] = ev_ovf;
      end
      s_d.sts[BIT_CARRY] = op_carry;
    end
    if (record)
    begin
      // set wins over a simultaneous status load
      s_d.sts[BIT_ERR] = 1'b1;
      if (ev_illegal)
        s_d.cause = CAUSE_OPCODE;
      else if (ev_undef)
        s_d.cause = CAUSE_UNDEF;
      else if (ev_divz)
        s_d.cause = CAUSE_DIVZ;
      else if (ev_cvt && s_q.sts[BIT_CVT_EN])
        s_d.cause = CAUSE_CVT;
      else if (ev_ovf && s_q.sts[BIT_OVF_EN])
        s_d.cause = CAUSE_OVF;
      else
        s_d.cause = CAUSE_UNF;
      s_d.addr = instr_addr;
      s_d.trap = !s_q.sts[BIT_GID];
    end
  end

  // no write path to cause or address exists besides exception capture
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      s_q.sts <= STS_RESET;
      s_q.cause <= CAUSE_RESET;
      s_q.addr <= ADDR_RESET;
      s_q.trap <= 1'b0;
      s_q.vec <= TRAP_VECTOR;
      s_q.rvalid <= 1'b0;
      s_q.res <= 64'h0000_0000_0000_0000;
      s_q.ires <= 32'h0000_0000;
      s_q.step <= STEP_SINGLE;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign status_word = s_q.sts;
  assign cause_code = s_q.cause;
  assign fault_addr = s_q.addr;
  assign trap_req = s_q.trap;
  assign trap_vector = s_q.vec;
  assign res_valid = s_q.rvalid;
  assign res_data = s_q.res;
  assign int_result = s_q.ires;
  assign addr_step = s_q.step;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  property p_gid_blocks_trap;
    s_q.sts[BIT_GID] |=> !trap_req;
  endproperty
  a_gid_blocks_trap: assert property (p_gid_blocks_trap) else $error("trap raised while globally disabled");

  property p_undef_trap;
    op_valid && !op_illegal && !illegal_ac && op_uses_src && op_mode != 3'h0
      && is_neg_zero_exp(src_msw) && s_q.sts[BIT_UNDEF_EN] && !s_q.sts[BIT_GID]
      |=> trap_req && cause_code == 4'hC && !res_valid;
  endproperty
  a_undef_trap: assert property (p_undef_trap) else $error("undefined operand did not trap");

  property p_mode0_no_undef;
    op_valid && op_mode == 3'h0 && !op_illegal && op_ac <= 3'h5 |=> !(trap_req && cause_code == 4'hC);
  endproperty
  a_mode0_no_undef: assert property (p_mode0_no_undef) else $error("accumulator operand raised undefined trap");

  property p_negzero_needs_err;
    res_valid && !$past(op_to_int) && res_data[63] && res_data[62:55] == 8'h00 |-> status_word[15];
  endproperty
  a_negzero_needs_err: assert property (p_negzero_needs_err) else $error("negative zero stored without exception");

  property p_ovf_disabled_zero;
    store && ev_ovf && !op_to_int && !s_q.sts[BIT_OVF_EN] && !record
      |=> res_valid && res_data == 64'h0 && !trap_req && status_word[1];
  endproperty
  a_ovf_disabled_zero: assert property (p_ovf_disabled_zero) else $error("disabled overflow not zeroed");

  property p_unf_disabled_zero;
    store && ev_unf && !op_to_int && !s_q.sts[BIT_UNF_EN] && !record |=> res_data == 64'h0 && !trap_req;
  endproperty
  a_unf_disabled_zero: assert property (p_unf_disabled_zero) else $error("disabled underflow not zeroed");

  property p_cvt_fail_zero;
    store && op_to_int && !cvt_ok
      |=> int_result == 32'h0 && status_word[2] && (trap_req == ($past(s_q.sts[BIT_CVT_EN]) && !$past(s_q.sts[BIT_GID])));
  endproperty
  a_cvt_fail_zero: assert property (p_cvt_fail_zero) else $error("failed conversion handled wrongly");

  property p_stable_capture;
    !op_valid |=> $stable(cause_code) && $stable(fault_addr);
  endproperty
  a_stable_capture: assert property (p_stable_capture) else $error("cause or address changed without exception");

  property p_err_sticky;
    status_word[15] && !stat_load |=> status_word[15];
  endproperty
  a_err_sticky: assert property (p_err_sticky) else $error("error bit cleared by hardware");

  property p_addr_capture;
    op_valid && op_div_zero && !op_illegal && !illegal_ac && !ev_undef
      |=> fault_addr == $past(instr_addr) && cause_code == 4'h4 && status_word[15];
  endproperty
  a_addr_capture: assert property (p_addr_capture) else $error("divide fault not captured");

  property p_step;
    ##1 addr_step == ($past(s_q.sts[7]) ? 4'h8 : 4'h4);
  endproperty
  a_step: assert property (p_step) else $error("autostep size wrong");

  property p_vector;
    trap_req |-> trap_vector == 9'h0A4;
  endproperty
  a_vector: assert property (p_vector) else $error("trap vector wrong");

  property p_ovf_trap;
    ev_ovf && s_q.sts[BIT_OVF_EN] && !ev_illegal && !ev_undef && !op_div_zero
      |=> cause_code == 4'h8 && status_word[1] && status_word[15] && res_valid && trap_req != $past(s_q.sts[BIT_GID]);
  endproperty
  a_ovf_trap: assert property (p_ovf_trap) else $error("enabled overflow not recorded");

  property p_unf_trap;
    ev_unf && s_q.sts[BIT_UNF_EN] && !ev_illegal && !ev_undef && !op_div_zero
      |=> cause_code == 4'hA && status_word[15] && res_valid && trap_req != $past(s_q.sts[BIT_GID]);
  endproperty
  a_unf_trap: assert property (p_unf_trap) else $error("enabled underflow not recorded");

  property p_illegal_ac;
    op_valid && op_ac > (op_mode == 3'h0 ? 3'h5 : 3'h3) |=> cause_code == 4'h2 && !res_valid && status_word[15];
  endproperty
  a_illegal_ac: assert property (p_illegal_ac) else $error("illegal accumulator not trapped");

  property p_load_err;
    stat_load && !record |=> status_word[15] == $past(stat_load_data[15]);
  endproperty
  a_load_err: assert property (p_load_err) else $error("error bit not taken from status load");

  // ----------------------------------------
  // Cover points
  // ----------------------------------------
  c_undef_trap: cover property (ev_undef ##1 trap_req);
  c_trap: cover property (trap_req);
  c_ovf_trap: cover property (op_valid && ev_ovf && s_q.sts[BIT_OVF_EN] ##1 trap_req);
  c_cvt_fail: cover property (op_valid && ev_cvt);
  c_gid_record: cover property (record && s_q.sts[BIT_GID]);

endmodule

// [sim/fpseu_cpu_model.sv]
// Behavioural stand-in for the CPU trap sequencer beside the floating unit.
// Assumes trap_req is a registered one-cycle pulse on the shared clock.
`timescale 1ns/10ps
module fpseu_cpu_model
  import fpseu_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic trap_req,
  input wire logic [8:0] trap_vector,
  output logic [7:0] trap_cnt,
  output logic [8:0] last_vec
);
  // ----------------------------------------
  // Trap intake
  // ----------------------------------------
  // Counting every pulse lets the bench spot a lost or doubled request
  // take vectored trap
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      trap_cnt <= 8'h00;
      last_vec <= 9'h000;
    end
    else if (trap_req)
    begin
      trap_cnt <= trap_cnt + 8'h01;
      last_vec <= trap_vector;
    end
  end
endmodule

// [sim/testbench.sv]
// Self-checking bench for the floating status and exception unit.
// Assumes registered outputs one cycle after an op_valid or stat_load pulse.
`timescale 1ns/10ps
module testbench;
  import fpseu_pkg::*;
  logic clk, rst, stat_load, op_valid, op_illegal, op_div_zero, op_uses_src;
  logic op_to_int, op_zero, res_sign, op_carry, trap_req, res_valid;
  logic [15:0] stat_load_data, instr_addr, src_msw, status_word, fault_addr, exp_addr;
  logic [2:0] op_mode, op_ac;
  logic signed [CVT_W-1:0] cvt_value;
  logic signed [9:0] res_exp;
  logic [FRAC_W:0] res_frac_raw;
  logic [3:0] cause_code, addr_step, exp_cause;
  logic [8:0] trap_vector, last_vec;
  logic [63:0] res_data;
  logic [31:0] int_result;
  logic [7:0] trap_cnt;
  int error_cnt = 0;
  int n_tests = 0;
  int exp_traps = 0;
  logic [2:0] md [5] = '{3'h0, 3'h0, 3'h0, 3'h1, 3'h1};
  logic [2:0] acs [5] = '{3'h6, 3'h7, 3'h5, 3'h4, 3'h3};
  logic bad [5] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b0};

  fpseu_unit DUT (.clk(clk), .rst(rst), .stat_load(stat_load), .stat_load_data(stat_load_data),
    .op_valid(op_valid), .instr_addr(instr_addr), .op_illegal(op_illegal), .op_div_zero(op_div_zero),
    .op_mode(op_mode), .op_ac(op_ac), .op_uses_src(op_uses_src), .src_msw(src_msw),
    .op_to_int(op_to_int), .cvt_value(cvt_value), .op_zero(op_zero), .res_sign(res_sign),
    .res_exp(res_exp), .res_frac_raw(res_frac_raw), .op_carry(op_carry), .status_word(status_word),
    .cause_code(cause_code), .fault_addr(fault_addr), .trap_req(trap_req), .trap_vector(trap_vector),
    .res_valid(res_valid), .res_data(res_data), .int_result(int_result), .addr_step(addr_step));

  fpseu_cpu_model cpu (.clk(clk), .rst(rst), .trap_req(trap_req), .trap_vector(trap_vector),
    .trap_cnt(trap_cnt), .last_vec(last_vec));

  // ----------------------------------------
  // Clock and watchdog
  // ----------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  initial
  begin
    repeat (5000) @(posedge clk);
    error_cnt++;
    end_sim();
  end

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic end_sim();
    if (error_cnt == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      error_cnt++;
    end
  endtask

  // Clean positive result, memory operand, nothing odd
  task automatic base();
    {op_illegal, op_div_zero, op_uses_src, op_to_int, op_zero, res_sign, op_carry} = 7'h00;
    op_mode = 3'h1;
    op_ac = 3'h0;
    src_msw = 16'h4080;
    cvt_value = '0;
    res_exp = 10'sd129;
    res_frac_raw = 57'h100000000000000;
  endtask

  task automatic ld(input logic [15:0] d);
    @(posedge clk);
    #1;
    stat_load = 1'b1;
    stat_load_data = d;
    @(posedge clk);
    #1;
    stat_load = 1'b0;
  endtask

  task automatic go(input logic upd, input logic [3:0] ecause, input logic etrap, input logic eres);
    @(posedge clk);
    #1;
    op_valid = 1'b1;
    instr_addr = instr_addr + 16'h0002;
    @(posedge clk);
    #1;
    op_valid = 1'b0;
    if (upd)
    begin
      exp_cause = ecause;
      exp_addr = instr_addr;
    end
    if (etrap)
      exp_traps++;
    chk(cause_code, exp_cause);
    chk(fault_addr, exp_addr);
    chk(trap_req, etrap);
    chk(res_valid, eres);
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    rst = 1'b1;
    {stat_load, op_valid} = 2'b00;
    stat_load_data = 16'h0000;
    instr_addr = 16'h1000;
    exp_cause = 4'h0;
    exp_addr = 16'h0000;
    base();
    repeat (8) @(posedge clk);
    chk({status_word, cause_code, fault_addr}, 36'h0);
    chk(trap_vector, 9'h0A4);
    #1;
    rst = 1'b0;
    ld(16'hFFFF);
    chk(status_word, 16'hCFEF);
    ld(16'h00A0);
    @(posedge clk);
    #1;
    chk(addr_step, 4'h8);
    // Double precision, round then chop on the first dropped bit
    ld(16'h0080);
    res_frac_raw = 57'h100000000000001;
    go(1'b0, 4'h0, 1'b0, 1'b1);
    chk(res_data, {1'b0, 8'h81, 55'h1});
    ld(16'h00A0);
    go(1'b0, 4'h0, 1'b0, 1'b1);
    chk(res_data, {1'b0, 8'h81, 55'h0});
    // Single precision rounding lands in the upper word only
    ld(16'h0000);
    res_frac_raw = 57'h100000100000000;
    go(1'b0, 4'h0, 1'b0, 1'b1);
    chk(res_data, {1'b0, 8'h81, 23'h1, 32'h0});
    chk(addr_step, 4'h4);
    // Condition bits
    ld(16'h0020);
    base();
    {res_sign, op_carry} = 2'b11;
    go(1'b0, 4'h0, 1'b0, 1'b1);
    chk(status_word, 16'h0029);
    base();
    op_zero = 1'b1;
    go(1'b0, 4'h0, 1'b0, 1'b1);
    chk({status_word, res_data}, {16'h0024, 64'h0});
    // Overflow enabled then disabled
    base();
    ld(16'h0220);
    res_exp = 10'sd300;
    go(1'b1, CAUSE_OVF, 1'b1, 1'b1);
    chk(res_data[63:55], 9'h02C);
    chk(status_word, 16'h8222);
    ld(16'h0020);
    go(1'b0, 4'h0, 1'b0, 1'b1);
    chk(status_word[15], 1'b0);
    chk(res_data, 64'h0);
    // Underflow enabled then disabled, and a stored minus zero with trap
    ld(16'h0420);
    res_exp = -10'sd10;
    go(1'b1, CAUSE_UNF, 1'b1, 1'b1);
    chk(res_data[62:55], 8'hF6);
    res_sign = 1'b1;
    res_exp = -10'sd256;
    go(1'b1, CAUSE_UNF, 1'b1, 1'b1);
    chk(res_data[63:55], 9'h100);
    ld(16'h0020);
    res_exp = -10'sd10;
    go(1'b0, 4'h0, 1'b0, 1'b1);
    chk(res_data, 64'h0);
    // Undefined operand: memory, accumulator, disabled, exact zero
    base();
    ld(16'h0820);
    op_uses_src = 1'b1;
    src_msw = 16'h807F;
    go(1'b1, CAUSE_UNDEF, 1'b1, 1'b0);
    op_mode = 3'h0;
    go(1'b0, 4'h0, 1'b0, 1'b1);
    op_mode = 3'h1;
    src_msw = 16'h0000;
    go(1'b0, 4'h0, 1'b0, 1'b1);
    ld(16'h0020);
    src_msw = 16'h8000;
    go(1'b0, 4'h0, 1'b0, 1'b1);
    // Divide by zero and illegal opcode trap with every enable clear
    base();
    op_div_zero = 1'b1;
    go(1'b1, CAUSE_DIVZ, 1'b1, 1'b0);
    op_illegal = 1'b1;
    go(1'b1, CAUSE_OPCODE, 1'b1, 1'b0);
    base();
    for (int i = 0; i < 5; i++)
    begin
      op_mode = md[i];
      op_ac = acs[i];
      go(bad[i], CAUSE_OPCODE, bad[i], !bad[i]);
    end
    // Integer conversion, short then long
    base();
    ld(16'h0120);
    op_to_int = 1'b1;
    cvt_value = 48'sd40000;
    go(1'b1, CAUSE_CVT, 1'b1, 1'b1);
    chk(int_result, 32'h0);
    cvt_value = -48'sd32768;
    go(1'b0, 4'h0, 1'b0, 1'b1);
    chk(int_result, 32'hFFFF8000);
    ld(16'h0160);
    cvt_value = 48'sd40000;
    go(1'b0, 4'h0, 1'b0, 1'b1);
    chk(int_result, 32'h00009C40);
    cvt_value = 48'sh80000000;
    go(1'b1, CAUSE_CVT, 1'b1, 1'b1);
    ld(16'h0040);
    go(1'b0, 4'h0, 1'b0, 1'b1);
    chk(int_result, 32'h0);
    // Global disable keeps recording but sends no trap
    base();
    ld(16'h4220);
    op_div_zero = 1'b1;
    go(1'b1, CAUSE_DIVZ, 1'b0, 1'b0);
    chk(status_word[15], 1'b1);
    base();
    res_exp = 10'sd300;
    go(1'b1, CAUSE_OVF, 1'b0, 1'b1);
    @(posedge clk);
    #1;
    chk(trap_cnt, exp_traps[7:0]);
    chk(last_vec, 9'h0A4);
    end_sim();
  end
endmodule
